// ===== hdl/smcs_monitor.sv
// Serial monitor command interpreter with entry security
`timescale 1ns/1ps
module smcs_monitor #(
   parameter int BIT_CYC = smcs_pkg::BIT_CYCLES
) (
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic por_in,
   input wire logic monitor_receive_pin_in,
   output logic monitor_transmit_pin_out,
   input wire logic [63:0] sec_code_in,
   input wire logic bulk_erase_in,
   input wire logic [15:0] stack_pointer_in,
   input wire logic addr_load_in,
   input wire logic [15:0] addr_load_value_in,
   output logic mem_req_out,
   output logic mem_we_out,
   output logic [15:0] mem_addr_out,
   output logic [7:0] mem_wdata_out,
   input wire logic mem_ack_in,
   input wire logic [7:0] mem_rdata_in,
   input wire logic exec_fetch_in,
   input wire logic [15:0] exec_addr_in,
   output logic illegal_addr_reset_out,
   output logic return_from_interrupt_out,
   output logic secure_ok_out,
   output logic cmd_ready_out
);
   import smcs_pkg::*;

   localparam int CW = $clog2(2 * BIT_CYC + 1);
   localparam logic [CW-1:0] BIT_N = CW'(BIT_CYC - 1);
   localparam logic [CW-1:0] HALF_N = CW'(BIT_CYC / 2 - 1);
   localparam logic [CW-1:0] BRK_N = CW'(2 * BIT_CYC - 1);

   // Counters need room for a half bit of at least two cycles
   if (BIT_CYC < 4) begin : g_bad_rate
      $error("BIT_CYC must be at least 4");
   end

   logic rx_s1_reg, rx_s2_reg, rx_s3_reg;
   logic [CW-1:0] tdiv_reg;
   logic bit_en_reg;
   logic rx_busy_reg, rx_wait_hi_reg, rx_v_reg;
   logic [CW-1:0] rcnt_reg;
   logic [3:0] rbit_reg;
   logic [8:0] rsh_reg;
   smcs_byte_t rx_d_reg;
   smcs_byte_t fifo_mem [2];
   logic wp_reg, rp_reg;
   logic [1:0] fcnt_reg;
   logic in_ready, push_v, psh, pop;
   smcs_byte_t push_d;
   logic tx_busy_reg, tx_pin_reg;
   logic [10:0] tsh_reg;
   logic [3:0] tbit_reg;
   smcs_state_t st_reg;
   logic pend_v_reg, take, sec_eq, rom_rd;
   smcs_byte_t pend_reg;
   logic [3:0] sec_cnt_reg;
   logic match_reg, secure_reg, done_reg, second_reg, illegal_reg;
   logic [15:0] last_reg, sp_reg, addr_reg;
   logic [7:0] rd_reg, wdata_reg;
   logic [CW-1:0] bcnt_reg;
   logic [63:0] code_reg;
   logic req_reg, we_reg, rfi_reg;

   // ------------------------------------------------------------
   // Receive pin and bit timing
   // ------------------------------------------------------------

   // Pin is asynchronous: two flops before anything looks at it
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         rx_s1_reg <= 1'b1;
         rx_s2_reg <= 1'b1;
         rx_s3_reg <= 1'b1;
      end else begin
         rx_s1_reg <= monitor_receive_pin_in;
         rx_s2_reg <= rx_s1_reg;
         rx_s3_reg <= rx_s2_reg;
      end
   end

   // Free bit-rate enable for the transmitter
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         tdiv_reg <= '0;
         bit_en_reg <= 1'b0;
      end else if (tdiv_reg == BIT_N) begin
         tdiv_reg <= '0;
         bit_en_reg <= 1'b1;
      end else begin
         tdiv_reg <= tdiv_reg + 1'b1;
         bit_en_reg <= 1'b0;
      end
   end

   // Receiver samples mid-bit; a break waits for the line to rise
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         rx_busy_reg <= 1'b0;
         rx_wait_hi_reg <= 1'b0;
         rx_v_reg <= 1'b0;
         rcnt_reg <= '0;
         rbit_reg <= '0;
         rsh_reg <= '0;
         rx_d_reg <= '0;
      end else begin
         rx_v_reg <= 1'b0;
         if (rx_wait_hi_reg) begin
            if (rx_s2_reg) begin
               rx_wait_hi_reg <= 1'b0;
            end
         end else if (!rx_busy_reg) begin
            if (rx_s3_reg && !rx_s2_reg) begin
               rx_busy_reg <= 1'b1;
               rcnt_reg <= HALF_N;
               rbit_reg <= '0;
            end
         end else if (rcnt_reg == '0) begin
            rcnt_reg <= BIT_N;
            rsh_reg <= {rx_s2_reg, rsh_reg[8:1]};
            rbit_reg <= rbit_reg + 1'b1;
            if (rbit_reg == RX_LAST_BIT) begin
               rx_busy_reg <= 1'b0;
               rx_v_reg <= 1'b1;
               rx_d_reg.data <= rsh_reg[8:1];
               // Low stop slot with zero data is a break
               rx_d_reg.brk <= !rx_s2_reg && (rsh_reg[8:1] == 8'h00);
               rx_wait_hi_reg <= !rx_s2_reg;
            end
         end else begin
            rcnt_reg <= rcnt_reg - 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Two-entry transmit buffer
   // ------------------------------------------------------------
   assign in_ready = (fcnt_reg != 2'd2);
   assign psh = push_v && in_ready;
   assign pop = (fcnt_reg != 2'd0) && !tx_busy_reg;

   // Entries without reset; only the pointers and the count need a defined start
   always_ff @(posedge sys_clk_in) begin
      if (psh) begin
         fifo_mem[wp_reg] <= push_d;
      end
   end

   // FIFO order keeps results behind their echo
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         wp_reg <= 1'b0;
         rp_reg <= 1'b0;
         fcnt_reg <= 2'd0;
      end else begin
         if (psh) begin
            wp_reg <= ~wp_reg;
         end
         if (pop) begin
            rp_reg <= ~rp_reg;
         end
         fcnt_reg <= fcnt_reg + {1'b0, psh} - {1'b0, pop};
      end
   end

   // ------------------------------------------------------------
   // Transmitter: 11 slots, LSB first, idle high
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         tx_busy_reg <= 1'b0;
         tx_pin_reg <= 1'b1;
         tsh_reg <= '1;
         tbit_reg <= '0;
      end else if (pop) begin
         tx_busy_reg <= 1'b1;
         tbit_reg <= '0;
         if (fifo_mem[rp_reg].brk) begin
            tsh_reg <= BRK_FRAME;
         end else begin
            tsh_reg <= {2'b11, fifo_mem[rp_reg].data, 1'b0};
         end
      end else if (tx_busy_reg && bit_en_reg) begin
         tx_pin_reg <= tsh_reg[0];
         tsh_reg <= {1'b1, tsh_reg[10:1]};
         tbit_reg <= tbit_reg + 1'b1;
         if (tbit_reg == TX_LAST_BIT) begin
            tx_busy_reg <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Command engine
   // ------------------------------------------------------------
   assign take = pend_v_reg && (pend_reg.brk || in_ready) &&
                 (st_reg inside {S_SEC, S_IDLE, S_IWD});
   assign sec_eq = (pend_reg.data == code_reg[sec_cnt_reg[2:0]*8 +: 8]);
   assign rom_rd = !secure_reg && (addr_reg >= ROM_LO);

   // One received byte waits here until the engine can echo it
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         pend_v_reg <= 1'b0;
         pend_reg <= '0;
      end else if (rx_v_reg) begin
         pend_v_reg <= 1'b1;
         pend_reg <= rx_d_reg;
      end else if (take) begin
         pend_v_reg <= 1'b0;
      end
   end

   // What goes into the buffer this cycle
   always_comb begin
      push_v = 1'b0;
      push_d = '0;
      case (st_reg)
         S_SEC, S_IDLE, S_IWD: begin
            push_v = pend_v_reg && !pend_reg.brk;
            push_d = pend_reg;
         end
         S_BRKD: begin
            push_v = (bcnt_reg == '0);
            push_d.brk = 1'b1;
         end
         S_BRK: begin
            push_v = 1'b1;
            push_d.brk = 1'b1;
         end
         S_RDP: begin
            push_v = 1'b1;
            push_d.data = rd_reg;
         end
         S_SPH: begin
            push_v = 1'b1;
            push_d.data = sp_reg[15:8];
         end
         S_SPL: begin
            push_v = 1'b1;
            push_d.data = sp_reg[7:0];
         end
         default: begin
         end
      endcase
   end

   // Code bytes, lowest address in the low byte
   always_ff @(posedge sys_clk_in) begin
      if (bulk_erase_in) begin
         code_reg <= {8{ERASED_BYTE}};
      end else if (!rst_b_in) begin
         code_reg <= sec_code_in;
      end
   end

   // Survives ordinary resets; a power-on reset reopens the check
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         if (por_in) begin
            secure_reg <= 1'b0;
            done_reg <= 1'b0;
         end
      end else if (st_reg == S_STAT && mem_ack_in) begin
         secure_reg <= match_reg;
         done_reg <= 1'b1;
      end
   end

   // ROM fetch while locked asks the system for a reset
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         illegal_reg <= 1'b0;
      end else begin
         illegal_reg <= exec_fetch_in && !secure_reg &&
                        (exec_addr_in >= ROM_LO);
      end
   end

   // Main sequencer
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         st_reg <= (done_reg && !por_in) ? S_IDLE : S_SEC;
         sec_cnt_reg <= '0;
         match_reg <= 1'b1;
         second_reg <= 1'b0;
         bcnt_reg <= '0;
         req_reg <= 1'b0;
         we_reg <= 1'b0;
         addr_reg <= '0;
         wdata_reg <= '0;
         rfi_reg <= 1'b0;
         rd_reg <= '0;
         sp_reg <= '0;
         last_reg <= LAST_ADDR_RST;
      end else begin
         rfi_reg <= 1'b0;
         case (st_reg)
            S_SEC: begin
               if (take && pend_reg.brk) begin
                  st_reg <= S_BRKD;
                  bcnt_reg <= BRK_N;
               end else if (take) begin
                  match_reg <= match_reg && sec_eq;
                  sec_cnt_reg <= sec_cnt_reg + 1'b1;
                  if (sec_cnt_reg == SEC_BYTES - 4'd1) begin
                     st_reg <= S_STAT;
                     req_reg <= 1'b1;
                     we_reg <= 1'b1;
                     addr_reg <= STAT_ADDR;
                     wdata_reg <= '0;
                     wdata_reg[STAT_SEC_BIT] <= match_reg && sec_eq;
                  end
               end
            end
            S_STAT: begin
               if (mem_ack_in) begin
                  req_reg <= 1'b0;
                  st_reg <= S_BRK;
               end
            end
            S_BRK: begin
               if (in_ready) begin
                  st_reg <= S_IDLE;
               end
            end
            S_BRKD: begin
               if (bcnt_reg != '0) begin
                  bcnt_reg <= bcnt_reg - 1'b1;
               end else if (in_ready) begin
                  st_reg <= done_reg ? S_IDLE : S_SEC;
               end
            end
            S_IDLE: begin
               if (addr_load_in) begin
                  last_reg <= addr_load_value_in;
               end
               if (take && pend_reg.brk) begin
                  st_reg <= S_BRKD;
                  bcnt_reg <= BRK_N;
               end else if (take) begin
                  case (pend_reg.data)
                     OP_INDEXED_READ: begin
                        st_reg <= S_RD;
                        req_reg <= 1'b1;
                        we_reg <= 1'b0;
                        addr_reg <= last_reg + 16'd1;
                        second_reg <= 1'b0;
                     end
                     OP_INDEXED_WRITE: begin
                        st_reg <= S_IWD;
                     end
                     OP_STACK_POINTER_READ: begin
                        st_reg <= S_SPH;
                        sp_reg <= stack_pointer_in;
                     end
                     OP_RUN: begin
                        rfi_reg <= 1'b1;
                     end
                     default: begin
                     end
                  endcase
               end
            end
            S_IWD: begin
               if (take && pend_reg.brk) begin
                  st_reg <= S_BRKD;
                  bcnt_reg <= BRK_N;
               end else if (take) begin
                  st_reg <= S_WR;
                  req_reg <= 1'b1;
                  we_reg <= 1'b1;
                  addr_reg <= last_reg + 16'd1;
                  wdata_reg <= pend_reg.data;
               end
            end
            S_RD: begin
               if (mem_ack_in) begin
                  req_reg <= 1'b0;
                  last_reg <= addr_reg;
                  rd_reg <= rom_rd ? LOCKED_BYTE : mem_rdata_in;
                  st_reg <= S_RDP;
               end
            end
            S_RDP: begin
               if (in_ready && second_reg) begin
                  st_reg <= S_IDLE;
               end else if (in_ready) begin
                  second_reg <= 1'b1;
                  st_reg <= S_RD;
                  req_reg <= 1'b1;
                  addr_reg <= last_reg + 16'd1;
               end
            end
            S_WR: begin
               if (mem_ack_in) begin
                  req_reg <= 1'b0;
                  last_reg <= addr_reg;
                  st_reg <= S_IDLE;
               end
            end
            S_SPH: begin
               if (in_ready) begin
                  st_reg <= S_SPL;
               end
            end
            S_SPL: begin
               if (in_ready) begin
                  st_reg <= S_IDLE;
               end
            end
            default: begin
               st_reg <= S_IDLE;
            end
         endcase
      end
   end

   // Outputs straight from flops
   assign monitor_transmit_pin_out = tx_pin_reg;
   assign mem_req_out = req_reg;
   assign mem_we_out = we_reg;
   assign mem_addr_out = addr_reg;
   assign mem_wdata_out = wdata_reg;
   assign illegal_addr_reset_out = illegal_reg;
   assign return_from_interrupt_out = rfi_reg;
   assign secure_ok_out = secure_reg;
   assign cmd_ready_out = done_reg;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);

   AST_INDEXED_READ_STEP: assert property (
      (st_reg == S_RD && mem_ack_in) |=>
      last_reg == $past(last_reg) + 16'd1) else $error("indexed read step");
   AST_INDEXED_READ_WRAP: assert property (
      (st_reg == S_RD && mem_ack_in && last_reg == 16'hFFFF) |=>
      last_reg == 16'h0000) else $error("no wrap");
   AST_INDEXED_WRITE_ADDR: assert property ((st_reg == S_WR) |->
      mem_req_out && mem_we_out && mem_addr_out == last_reg + 16'd1)
      else $error("indexed write addr");
   AST_SP_ORDER: assert property ((st_reg == S_SPH && psh) |->
      push_d.data == sp_reg[15:8] ##1 st_reg == S_SPL) else $error("sp");
   AST_RUN: assert property ((st_reg == S_IDLE && take && !pend_reg.brk &&
      pend_reg.data == OP_RUN) |=> return_from_interrupt_out)
      else $error("run");
   AST_LOCKED_IDLE: assert property (!done_reg |->
      !return_from_interrupt_out && !(st_reg inside {S_RD, S_WR, S_SPH}))
      else $error("command before security");
   AST_ROM_LOCK: assert property ((st_reg == S_RD && mem_ack_in &&
      !secure_reg && mem_addr_out >= ROM_LO) |=> rd_reg == LOCKED_BYTE)
      else $error("rom not hidden");
   AST_BRK_AFTER8: assert property ((st_reg == S_BRK) |->
      sec_cnt_reg == SEC_BYTES) else $error("early break");
   AST_STATUS: assert property ((st_reg == S_STAT) |->
      mem_addr_out == STAT_ADDR &&
      mem_wdata_out[STAT_SEC_BIT] == match_reg) else $error("status");
   AST_ECHO: assert property ((st_reg == S_IDLE && take &&
      !pend_reg.brk) |-> psh && push_d == pend_reg) else $error("echo");
   AST_BRK_WAIT: assert property ((rx_v_reg && rx_d_reg.brk &&
      st_reg == S_IDLE && !pend_v_reg) |-> ##2 st_reg == S_BRKD &&
      bcnt_reg == BRK_N) else $error("break delay");

   COV_SEC_PASS: cover property (st_reg == S_STAT && mem_ack_in && match_reg);
   COV_INDEXED_READ: cover property (st_reg == S_RDP && psh && second_reg);
   COV_RUN: cover property (return_from_interrupt_out);
   COV_FULL: cover property (fcnt_reg == 2'd2);

endmodule

// ===== hdl/smcs_pkg.sv
// Constants, carrier types and states of the serial monitor block
package smcs_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 200_000_000;
   localparam int BAUD = 9600;
   localparam int BIT_CYCLES = CLK_HZ / BAUD;

   // ------------------------------------------------------------
   // Command opcodes
   // ------------------------------------------------------------
   localparam logic [7:0] OP_INDEXED_READ = 8'h1A;
   localparam logic [7:0] OP_INDEXED_WRITE = 8'h19;
   localparam logic [7:0] OP_STACK_POINTER_READ = 8'h0C;
   localparam logic [7:0] OP_RUN = 8'h28;

   // ------------------------------------------------------------
   // Security and memory map
   // ------------------------------------------------------------
   localparam logic [3:0] SEC_BYTES = 4'h8;
   localparam logic [15:0] STAT_ADDR = 16'h0060;
   localparam int STAT_SEC_BIT = 6;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] LOCKED_BYTE = 8'h00;
   localparam logic [15:0] ROM_LO = 16'hE000;
   localparam logic [15:0] LAST_ADDR_RST = 16'h0000;

   // ------------------------------------------------------------
   // Framing: start, 8 data, stop, one spare stop slot
   // ------------------------------------------------------------
   localparam logic [3:0] RX_LAST_BIT = 4'h9;
   localparam logic [3:0] TX_LAST_BIT = 4'hA;
   localparam logic [10:0] BRK_FRAME = 11'h400;

   typedef struct packed {
      logic brk;
      logic [7:0] data;
   } smcs_byte_t;

   typedef enum logic [10:0] {
      S_SEC  = 11'h001,
      S_STAT = 11'h002,
      S_BRK  = 11'h004,
      S_BRKD = 11'h008,
      S_IDLE = 11'h010,
      S_IWD  = 11'h020,
      S_RD   = 11'h040,
      S_RDP  = 11'h080,
      S_WR   = 11'h100,
      S_SPH  = 11'h200,
      S_SPL  = 11'h400
   } smcs_state_t;

endpackage

// ===== tb/smcs_host_model.sv
// Host side of the monitor serial link: frame sender and frame catcher
`timescale 1ns/1ps
module smcs_host_model #(
   parameter int BIT_CYC = 16
) (
   input wire logic sys_clk_in,
   input wire logic line_from_dev_in,
   output logic line_to_dev_out
);
   import smcs_pkg::*;
   smcs_byte_t rx_q[$];
   logic [7:0] cap;
   logic cap_brk;

   // ------------------------------------------------------------
   // Sender
   // ------------------------------------------------------------
   initial line_to_dev_out = 1'b1;

   // NRZ frame, LSB first; a break is ten low slots
   task automatic send(input logic [7:0] d, input logic brk);
      logic [9:0] f;
      f = brk ? 10'h000 : {1'b1, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         line_to_dev_out = f[i];
         repeat (BIT_CYC) @(negedge sys_clk_in);
      end
      line_to_dev_out = 1'b1;
      repeat (BIT_CYC) @(negedge sys_clk_in);
   endtask

   // ------------------------------------------------------------
   // Catcher
   // ------------------------------------------------------------
   // Mid-bit sampling at the same rate; low stop with zero data is a break
   always begin
      @(negedge line_from_dev_in);
      repeat (BIT_CYC / 2) @(posedge sys_clk_in);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYC) @(posedge sys_clk_in);
         cap[i] = line_from_dev_in;
      end
      repeat (BIT_CYC) @(posedge sys_clk_in);
      cap_brk = !line_from_dev_in && (cap == 8'h00);
      rx_q.push_back({cap_brk, cap});
      // Waiting for idle keeps a long break from looking like two frames
      while (!line_from_dev_in) @(posedge sys_clk_in);
   end
endmodule

// ===== tb/serial_monitor_command_security_tb.sv
// Self-checking bench for the serial monitor block
`timescale 1ns/1ps
module serial_monitor_command_security_tb;
   import smcs_pkg::*;
   localparam int BC = 16;
   logic clk = 1'b0, rst_b = 1'b0, por = 1'b1, rx, tx, bulk = 1'b0;
   logic [63:0] code = 64'h0;
   logic [15:0] sp = 16'h0, ld_val = 16'h0, addr, fa = 16'h0, wr_a;
   logic ld = 1'b0, req, we, ack = 1'b0, fetch = 1'b0, ill, rfi, ok, rdy;
   logic [7:0] wd, rd = 8'h00, wr_d, d;
   logic [7:0] mem [0:65535];
   int err_count = 0, comparisons = 0, rfi_n = 0;
   smcs_byte_t b;

   smcs_monitor #(.BIT_CYC(BC)) smcs_monitor_inst (.sys_clk_in(clk),
      .rst_b_in(rst_b), .por_in(por), .monitor_receive_pin_in(rx),
      .monitor_transmit_pin_out(tx), .sec_code_in(code),
      .bulk_erase_in(bulk), .stack_pointer_in(sp), .addr_load_in(ld),
      .addr_load_value_in(ld_val), .mem_req_out(req), .mem_we_out(we),
      .mem_addr_out(addr), .mem_wdata_out(wd), .mem_ack_in(ack),
      .mem_rdata_in(rd), .exec_fetch_in(fetch), .exec_addr_in(fa),
      .illegal_addr_reset_out(ill), .return_from_interrupt_out(rfi),
      .secure_ok_out(ok), .cmd_ready_out(rdy));
   smcs_host_model #(.BIT_CYC(BC)) smcs_host_model_inst (
      .sys_clk_in(clk), .line_from_dev_in(tx), .line_to_dev_out(rx));

   // ------------------------------------------------------------
   // Clock, memory and pulse counter
   // ------------------------------------------------------------
   initial forever #2.5 clk = ~clk;

   // One-cycle ack after each request; writes are logged
   always @(negedge clk) begin
      if (req && !ack) begin
         ack <= 1'b1;
         rd <= mem[addr];
         if (we) begin
            mem[addr] <= wd;
            wr_a <= addr;
            wr_d <= wd;
         end
      end else begin
         ack <= 1'b0;
      end
   end
   // Counted mid-cycle, away from the edge that launches the pulse
   always @(negedge clk) if (rfi === 1'b1) rfi_n++;

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input string nm, input logic [15:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_sim;
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic get_rx(input logic [8:0] exp);
      int n = 0;
      while (smcs_host_model_inst.rx_q.size() == 0 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      b = (n < 2000) ? smcs_host_model_inst.rx_q.pop_front() : 9'h1FF;
      check("tx_frame", {7'h00, b}, {7'h00, exp});
   endtask

   // Send one frame and expect its echo first
   task automatic xfer(input logic [7:0] v, input logic brk);
      smcs_host_model_inst.send(v, brk);
      get_rx({brk, v});
   endtask

   task automatic reset_dut(input logic p);
      @(negedge clk);
      rst_b = 1'b0;
      por = p;
      repeat (8) @(negedge clk);
      rst_b = 1'b1;
      por = 1'b0;
   endtask

   task automatic sec_phase(input logic [63:0] c, input logic pass);
      for (int i = 0; i < 8; i++) xfer(c[i*8+:8], 1'b0);
      get_rx(9'h100);
      check("status_addr", wr_a, STAT_ADDR);
      check("status", {8'h00, wr_d}, {8'h00, 1'b0, pass, 6'h00});
      check("secure", {15'h0, ok}, {15'h0, pass});
      check("ready", {15'h0, rdy}, 16'h0001);
   endtask

   task automatic load_addr(input logic [15:0] a);
      ld = 1'b1;
      ld_val = a;
      @(negedge clk);
      ld = 1'b0;
   endtask

   task automatic fetch_chk(input logic [15:0] a, input logic exp);
      fetch = 1'b1;
      fa = a;
      @(negedge clk);
      fetch = 1'b0;
      check("illegal", {15'h0, ill}, {15'h0, exp});
   endtask

   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      #(60000 * 5);
      err_count++;
      end_sim;
   end

   initial begin
      void'($urandom(66989));
      for (int i = 0; i < 65536; i++) mem[i] = $urandom;
      mem[16'hE000] = 8'hA5;
      mem[16'hE001] = 8'h3C;
      code = {$urandom, $urandom};
      reset_dut(1'b1);
      sec_phase(code, 1'b1);
      fetch_chk(16'hE000, 1'b0);
      // Indexed read across the top of the map
      load_addr(16'hFFFE);
      xfer(OP_INDEXED_READ, 1'b0);
      get_rx({1'b0, mem[16'hFFFF]});
      get_rx({1'b0, mem[16'h0000]});
      d = $urandom;
      xfer(OP_INDEXED_WRITE, 1'b0);
      xfer(d, 1'b0);
      repeat (4 * BC) @(negedge clk);
      check("indexed_write_addr", wr_a, 16'h0001);
      check("indexed_write_data", {8'h00, wr_d}, {8'h00, d});
      xfer(8'h00, 1'b1);
      // Warm reset keeps the unlocked state
      reset_dut(1'b0);
      check("warm_secure", {14'h0, ok, rdy}, 16'h0003);
      sp = $urandom;
      // Unknown opcode is echoed and then ignored
      xfer(8'hA5, 1'b0);
      xfer(OP_STACK_POINTER_READ, 1'b0);
      get_rx({1'b0, sp[15:8]});
      get_rx({1'b0, sp[7:0]});
      d = rfi_n;
      xfer(OP_RUN, 1'b0);
      repeat (2 * BC) @(negedge clk);
      check("run_pulses", 16'(rfi_n), {8'h00, d + 8'h01});
      // Retry only through power-on reset, with one wrong byte
      reset_dut(1'b1);
      sec_phase(code ^ 64'h0100_0000_0000_0000, 1'b0);
      load_addr(16'hDFFF);
      xfer(OP_INDEXED_READ, 1'b0);
      get_rx({1'b0, LOCKED_BYTE});
      get_rx({1'b0, LOCKED_BYTE});
      fetch_chk(16'hE000, 1'b1);
      // Erased code bytes read back as all ones
      reset_dut(1'b1);
      bulk = 1'b1;
      @(negedge clk);
      bulk = 1'b0;
      sec_phase({8{ERASED_BYTE}}, 1'b1);
      end_sim;
   end
endmodule
